// ---- hdl/ect_event_counter_timer.sv ----
/*
  Event counter timer: 16-bit counter advancing on selected edges of an
  external timer input pin or of the on-chip comparator output, with
  reload, output toggle and high-byte-first read latch. AHB-Lite slave.
  Assumes timerIn and cmpOut are asynchronous to clock.
*/
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module ect_event_counter_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Event sources
  input wire logic timerIn,
  input wire logic cmpOut,
  // Timer outputs
  output logic timerOut,
  output logic reloadReq
);
  // ==========================================================
  // Registers
  logic [7:0] ctrl_q;
  logic [15:0] count_q;
  logic [15:0] reload_q;
  logic [7:0] hold_q;
  logic reqSticky_q;
  logic out_q;
  logic [31:0] rdata_q;
  logic enable;
  logic polarity;
  logic modeCmp;
  assign enable = ctrl_q[ect_pkg::CTRL_EN_BIT];
  assign polarity = ctrl_q[ect_pkg::CTRL_POL_BIT];
  assign modeCmp = ctrl_q[ect_pkg::CTRL_MODE_BIT];

  // ==========================================================
  // Bus address phase capture
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic active;
  logic rdNow;
  logic wrNow;
  assign active = hsel && hready &&
    (htrans == ect_pkg::HTRANS_NONSEQ || htrans == ect_pkg::HTRANS_SEQ);
  assign rdNow = active && !hwrite;
  assign wrNow = wrPend_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end else begin
      wrPend_q <= active && hwrite;
      if (active) begin
        wrAddr_q <= haddr[7:0];
      end
    end
  end

  // ==========================================================
  // Input synchronisers and edge detection
  logic [1:0] pinSync_q;
  logic [1:0] cmpSync_q;
  logic srcPrev_q;
  logic src;
  logic edgeHit;
  always_ff @(posedge clock) begin
    if (rst) begin
      pinSync_q <= 2'b00;
      cmpSync_q <= 2'b00;
    end else begin
      pinSync_q <= {pinSync_q[0], timerIn};
      cmpSync_q <= {cmpSync_q[0], cmpOut};
    end
  end
  // Comparator path passes the same two-flop synchroniser as the pin, no prescaler
  assign src = modeCmp ? cmpSync_q[1] : pinSync_q[1];
  always_ff @(posedge clock) begin
    if (rst) begin
      srcPrev_q <= 1'b0;
    end else begin
      srcPrev_q <= src;
    end
  end
  // Polarity 0 rising, 1 falling, for either source
  assign edgeHit = enable && (polarity ? (srcPrev_q && !src) : (!srcPrev_q && src));

  // ==========================================================
  // Counter
  logic atReload;
  logic doReload;
  assign atReload = (count_q == reload_q);
  assign doReload = edgeHit && atReload;
  logic wrCntHi;
  logic wrCntLo;
  assign wrCntHi = wrNow && wrAddr_q == ect_pkg::CNT_HI_OFS;
  assign wrCntLo = wrNow && wrAddr_q == ect_pkg::CNT_LO_OFS;

  always_ff @(posedge clock) begin
    if (rst) begin
      count_q <= {ect_pkg::CNT_HI_RST, ect_pkg::CNT_LO_RST};
    end else if (wrCntHi || wrCntLo) begin
      // Byte writes land directly, no write latch; a racing edge is lost
      if (wrCntHi) begin
        count_q[15:8] <= hwdata[7:0];
      end
      if (wrCntLo) begin
        count_q[7:0] <= hwdata[7:0];
      end
    end else if (doReload) begin
      count_q <= ect_pkg::RESTART_VAL;
    end else if (edgeHit) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // ==========================================================
  // Timer output and reload request
  always_ff @(posedge clock) begin
    if (rst) begin
      out_q <= 1'b0;
    end else if (!enable) begin
      out_q <= polarity;
    end else if (doReload) begin
      out_q <= !out_q;
    end
  end
  assign timerOut = out_q;

  logic clrReq;
  assign clrReq = wrNow && wrAddr_q == ect_pkg::STAT_OFS && hwdata[0];
  always_ff @(posedge clock) begin
    if (rst) begin
      reqSticky_q <= 1'b0;
    end else if (doReload) begin
      reqSticky_q <= 1'b1;
    end else if (clrReq) begin
      reqSticky_q <= 1'b0;
    end
  end
  assign reloadReq = reqSticky_q;

  // ==========================================================
  // Control and reload registers
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q <= ect_pkg::CTRL_RST;
      reload_q <= ect_pkg::RLD_RST;
    end else if (wrNow) begin
      if (wrAddr_q == ect_pkg::CTRL_OFS) begin
        ctrl_q <= hwdata[7:0];
      end
      if (wrAddr_q == ect_pkg::RLD_HI_OFS) begin
        reload_q[15:8] <= hwdata[7:0];
      end
      if (wrAddr_q == ect_pkg::RLD_LO_OFS) begin
        reload_q[7:0] <= hwdata[7:0];
      end
    end
  end

  // ==========================================================
  // Read path with high-first latch
  always_ff @(posedge clock) begin
    if (rst) begin
      hold_q <= 8'h00;
    end else if (rdNow && enable && haddr[7:0] == ect_pkg::CNT_HI_OFS) begin
      hold_q <= count_q[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (rdNow) begin
      case (haddr[7:0])
        ect_pkg::CTRL_OFS: rdata_q <= {24'h00_0000, ctrl_q};
        ect_pkg::CNT_HI_OFS: rdata_q <= {24'h00_0000, count_q[15:8]};
        ect_pkg::CNT_LO_OFS: begin
          // Enabled reads see the latched byte so hi/lo pair is coherent
          rdata_q <= {24'h00_0000, enable ? hold_q : count_q[7:0]};
        end
        ect_pkg::RLD_HI_OFS: rdata_q <= {24'h00_0000, reload_q[15:8]};
        ect_pkg::RLD_LO_OFS: rdata_q <= {24'h00_0000, reload_q[7:0]};
        ect_pkg::STAT_OFS: rdata_q <= {30'h0, out_q, reqSticky_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Sequences for multi-step checks
  // Two quiet disabled cycles: no control write may move polarity between them
  sequence seqDisabledPair;
    (!enable && !wrNow) ##1 (!enable);
  endsequence
  // Source held across one detector step, so a mux switch cannot fake an edge
  sequence seqCmpSteady;
    modeCmp ##1 (modeCmp && enable);
  endsequence
  sequence seqPinSteady;
    !modeCmp ##1 (!modeCmp && enable);
  endsequence

  // ==========================================================
  // Checks
  AST_TOGGLE: assert property (@(posedge clock) disable iff (rst)
    (doReload && enable && !wrNow) |=> (timerOut != $past(timerOut)))
    else $error("output did not toggle on reload");
  AST_RESTART: assert property (@(posedge clock) disable iff (rst)
    (doReload && !wrCntHi && !wrCntLo) |=> (count_q == 16'h0001))
    else $error("counter did not restart at one");
  AST_POLLVL: assert property (@(posedge clock) disable iff (rst)
    seqDisabledPair |-> (timerOut == polarity))
    else $error("disabled output not at polarity");
  AST_INC: assert property (@(posedge clock) disable iff (rst)
    (edgeHit && !atReload && !wrCntHi && !wrCntLo) |=> (count_q == $past(count_q) + 16'h0001))
    else $error("counter did not advance");
  AST_STOP: assert property (@(posedge clock) disable iff (rst)
    (!enable && !wrCntHi && !wrCntLo) |=> $stable(count_q))
    else $error("disabled counter moved");
  AST_HOLD: assert property (@(posedge clock) disable iff (rst)
    (rdNow && enable && haddr[7:0] == ect_pkg::CNT_HI_OFS) |=> (hold_q == $past(count_q[7:0])))
    else $error("holding byte not captured");
  AST_LORD: assert property (@(posedge clock) disable iff (rst)
    (rdNow && enable && haddr[7:0] == ect_pkg::CNT_LO_OFS) |=> (hrdata[7:0] == $past(hold_q)))
    else $error("low read bypassed holding byte");
  AST_LOLIVE: assert property (@(posedge clock) disable iff (rst)
    (rdNow && !enable && haddr[7:0] == ect_pkg::CNT_LO_OFS) |=>
      (hrdata[7:0] == $past(count_q[7:0])))
    else $error("disabled low read not live");
  AST_WRLO: assert property (@(posedge clock) disable iff (rst)
    wrCntLo |=> (count_q[7:0] == $past(hwdata[7:0])))
    else $error("count low write not loaded");
  AST_REQ: assert property (@(posedge clock) disable iff (rst)
    doReload |=> reloadReq)
    else $error("reload request not raised");
  AST_CMPEDGE: assert property (@(posedge clock) disable iff (rst)
    seqCmpSteady ##0 (polarity ? $fell(cmpSync_q[1]) : $rose(cmpSync_q[1])) |-> edgeHit)
    else $error("comparator edge not counted");
  AST_SRCSEL: assert property (@(posedge clock) disable iff (rst)
    seqCmpSteady ##0 $stable(cmpSync_q[1]) |-> !edgeHit)
    else $error("edge counted without comparator change");
  AST_PINEDGE: assert property (@(posedge clock) disable iff (rst)
    seqPinSteady ##0 (polarity ? $fell(pinSync_q[1]) : $rose(pinSync_q[1])) |-> edgeHit)
    else $error("pin edge not counted");
  AST_WRHI: assert property (@(posedge clock) disable iff (rst)
    wrCntHi |=> (count_q[15:8] == $past(hwdata[7:0])))
    else $error("count high write not loaded");
  AST_HIRD: assert property (@(posedge clock) disable iff (rst)
    (rdNow && haddr[7:0] == ect_pkg::CNT_HI_OFS) |=>
      (hrdata == {24'h00_0000, $past(count_q[15:8])}))
    else $error("count high read not live");
  AST_REQKEEP: assert property (@(posedge clock) disable iff (rst)
    (reloadReq && !clrReq) |=> reloadReq)
    else $error("reload request dropped without clear");
  AST_CTRLWR: assert property (@(posedge clock) disable iff (rst)
    (wrNow && wrAddr_q == ect_pkg::CTRL_OFS) |=> (ctrl_q == $past(hwdata[7:0])))
    else $error("control write not stored");
  // Reload compare is only as good as the stored reload bytes
  AST_RLDLO: assert property (@(posedge clock) disable iff (rst)
    (wrNow && wrAddr_q == ect_pkg::RLD_LO_OFS) |=> (reload_q[7:0] == $past(hwdata[7:0])))
    else $error("reload low write not stored");
  AST_RLDHI: assert property (@(posedge clock) disable iff (rst)
    (wrNow && wrAddr_q == ect_pkg::RLD_HI_OFS) |=> (reload_q[15:8] == $past(hwdata[7:0])))
    else $error("reload high write not stored");
  AST_HOLDKEEP: assert property (@(posedge clock) disable iff (rst)
    !(rdNow && enable && haddr[7:0] == ect_pkg::CNT_HI_OFS) |=> $stable(hold_q))
    else $error("holding byte moved without high read");
  AST_OUTHOLD: assert property (@(posedge clock) disable iff (rst)
    (enable && !doReload) |=> $stable(timerOut))
    else $error("enabled output moved without reload");
endmodule

// ---- shared/ect_pkg.sv ----
/*
  Constants for the event counter timer: register offsets, control field
  positions and reset values.
  Assumes a 32-bit AHB-Lite slave with one register per aligned word.
*/
package ect_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CNT_HI_OFS = 8'h04;
  localparam logic [7:0] CNT_LO_OFS = 8'h08;
  localparam logic [7:0] RLD_HI_OFS = 8'h0c;
  localparam logic [7:0] RLD_LO_OFS = 8'h10;
  localparam logic [7:0] STAT_OFS = 8'h14;
  // ==========================================================
  // Control fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_POL_BIT = 6;
  localparam int CTRL_MODE_BIT = 0;
  localparam logic MODE_PIN = 1'b0;
  localparam logic MODE_CMP = 1'b1;
  // ==========================================================
  // Reset values and the reload restart value
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CNT_HI_RST = 8'h00;
  localparam logic [7:0] CNT_LO_RST = 8'h01;
  localparam logic [15:0] RLD_RST = 16'hffff;
  localparam logic [15:0] RESTART_VAL = 16'h0001;
  // ==========================================================
  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ = 2'b11;
endpackage

// ---- tb/ect_event_source.sv ----
/* Model of the timer input pin and the comparator output.
   Assumes each call starts right after a rising clock edge. */
`timescale 1ns/1ps
module ect_event_source (
  // Clock
  input wire logic clock,
  // Event lines
  output logic timerIn,
  output logic cmpOut
);
  initial begin
    timerIn = 1'b0;
    cmpOut = 1'b0;
  end
  // ==========================================
  // Level change
  // Held 4 cycles so synchroniser and counter settle
  task automatic drive(input logic useCmp, input logic lvl);
    if (useCmp) begin
      cmpOut <= lvl;
    end else begin
      timerIn <= lvl;
    end
    repeat (4) @(posedge clock);
  endtask
endmodule

// ---- tb/tb_top.sv ----
/* Self-checking bench for the event counter timer.
   Assumes a zero-wait AHB-Lite slave and the event source model. */
`timescale 1ns/1ps
module tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp, timerIn, cmpOut, timerOut, reloadReq;
  logic [31:0] hrdata, rd;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  always #4 clock = ~clock;
  ect_event_source src (.clock(clock), .timerIn(timerIn), .cmpOut(cmpOut));
  ect_event_counter_timer dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .timerIn(timerIn), .cmpOut(cmpOut), .timerOut(timerOut), .reloadReq(reloadReq));
  // ==========================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= ect_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask
  task automatic expRd(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h0);
    check(rd, {24'h0, exp});
  endtask
  // High byte first, so the low byte is the latched one when enabled
  task automatic expCnt(input logic [15:0] exp);
    expRd(ect_pkg::CNT_HI_OFS, exp[15:8]);
    expRd(ect_pkg::CNT_LO_OFS, exp[7:0]);
  endtask
  // ==========================================
  // Scenarios
  task automatic test_reset;
    expRd(ect_pkg::CTRL_OFS, ect_pkg::CTRL_RST);
    expCnt(ect_pkg::RESTART_VAL);
    expRd(ect_pkg::RLD_LO_OFS, 8'hff);
    expRd(8'h40, 8'h00);
    check(timerOut, 1'b0);
    check(hresp, 1'b0);
    $display("test_reset done");
  endtask
  task automatic test_pin;
    bus(1'b1, ect_pkg::CTRL_OFS, 8'h00);
    bus(1'b1, ect_pkg::CNT_HI_OFS, 8'h00);
    bus(1'b1, ect_pkg::CNT_LO_OFS, 8'h02);
    bus(1'b1, ect_pkg::RLD_HI_OFS, 8'h00);
    bus(1'b1, ect_pkg::RLD_LO_OFS, 8'h03);
    src.drive(1'b0, 1'b1);
    src.drive(1'b0, 1'b0);
    expCnt(16'h0002);
    bus(1'b1, ect_pkg::CTRL_OFS, 8'h80);
    src.drive(1'b0, 1'b1);
    expCnt(16'h0003);
    src.drive(1'b0, 1'b0);
    expCnt(16'h0003);
    src.drive(1'b0, 1'b1);
    expCnt(16'h0001);
    check(timerOut, 1'b1);
    check(reloadReq, 1'b1);
    for (int i = 0; i < 2; i++) begin
      src.drive(1'b0, 1'b0);
      src.drive(1'b0, 1'b1);
    end
    expCnt(16'h0003);
    bus(1'b0, ect_pkg::CNT_HI_OFS, 8'h0);
    src.drive(1'b0, 1'b0);
    src.drive(1'b0, 1'b1);
    expRd(ect_pkg::CNT_LO_OFS, 8'h03);
    check(timerOut, 1'b0);
    bus(1'b1, ect_pkg::STAT_OFS, 8'h01);
    bus(1'b1, ect_pkg::CNT_LO_OFS, 8'h10);
    src.drive(1'b0, 1'b0);
    src.drive(1'b0, 1'b1);
    expCnt(16'h0011);
    check(reloadReq, 1'b0);
    bus(1'b1, ect_pkg::CTRL_OFS, 8'h00);
    src.drive(1'b0, 1'b0);
    src.drive(1'b0, 1'b1);
    bus(1'b1, ect_pkg::CNT_LO_OFS, 8'h22);
    expRd(ect_pkg::CNT_LO_OFS, 8'h22);
    $display("test_pin done");
  endtask
  task automatic test_pol_cmp;
    bus(1'b1, ect_pkg::CTRL_OFS, 8'h40);
    // Output follows polarity one edge after the control write lands
    repeat (2) @(posedge clock);
    check(timerOut, 1'b1);
    expRd(ect_pkg::STAT_OFS, 8'h02);
    bus(1'b1, ect_pkg::CNT_LO_OFS, 8'h01);
    bus(1'b1, ect_pkg::CTRL_OFS, 8'hc0);
    src.drive(1'b0, 1'b0);
    src.drive(1'b0, 1'b1);
    expCnt(16'h0002);
    bus(1'b1, ect_pkg::CTRL_OFS, 8'h41);
    bus(1'b1, ect_pkg::CTRL_OFS, 8'hc1);
    src.drive(1'b1, 1'b1);
    src.drive(1'b1, 1'b0);
    expCnt(16'h0003);
    src.drive(1'b0, 1'b0);
    expCnt(16'h0003);
    bus(1'b1, ect_pkg::CTRL_OFS, 8'h81);
    src.drive(1'b1, 1'b1);
    // Count sat at the reload value, so this single edge reloads
    expCnt(16'h0001);
    check(reloadReq, 1'b1);
    $display("test_pol_cmp done");
  endtask
  // ==========================================
  // Verdict and run control
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Whole run is under 2000 cycles; ceiling leaves ample margin
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    test_reset();
    test_pin();
    test_pol_cmp();
    summarize();
  end
endmodule
